// ===== design/j1939_bam_multipacket_receiver.sv
// Contract
// RULE_01 - Groups to eight bytes ride one frame; 9 to 1785 use transport.
// RULE_02 - Connection-management byte one decodes announce, request, clear, acknowledge, abort.
// RULE_03 - Data frames carry sequence byte plus seven payload bytes.
// RULE_04 - Transport frames accepted only for own address or global FF.
// RULE_05 - Announced data accepted only when group interests us; no acknowledge sent.
// RULE_06 - Only broadcast announce reception; request and clear frames ignored.
// RULE_07 - No 200ms wait limit; no hold or disconnect timeout.
// RULE_08 - Reassembly buffer holds groups up to 500 bytes.
// RULE_09 - Connection scheme: request, clear, data, acknowledge by responder.
// RULE_10 - Connection scheme: responder alone holds and aborts connections.
// RULE_11 - Diagnostic group 0xFECA is variable length, may arrive multi-packet.
// RULE_12 - Diagnostic byte one is lamp state; four-byte codes follow.
// RULE_13 - Each mapped group takes four consecutive words; next follows directly.
// RULE_14 - Words carry raw values; consumer applies resolution and offset.
// RULE_15 - Odd byte to high half, following even byte to low half.
// RULE_16 - Size and count from announce; place by sequence; drop oversize.
`timescale 1ns/100ps
`default_nettype none
module j1939_bam_multipacket_receiver
   import j1939_rx_pkg::*;
#(
   parameter int BUF_BYTES = BUF_LIMIT,
   parameter int MAP_N     = 2,
   parameter int ROWS      = (BUF_BYTES + DT_PAYLOAD - 1) / DT_PAYLOAD,
   parameter int RW        = $clog2(ROWS)
) (
   input  wire logic                      clock_in,
   input  wire logic                      rst_n_in,
   input  wire logic                      frame_valid_in,
   input  wire can_frame_t                frame_in,
   input  wire logic [7:0]                own_addr_in,
   input  wire logic [17:0]               watch_pgn_in,
   input  wire logic [MAP_N-1:0][17:0]    map_pgn_in,
   input  wire logic [RW-1:0]             rd_row_in,
   output var  logic                      map_we_out,
   output var  logic [7:0]                map_base_out,
   output var  logic [MAP_WORDS-1:0][15:0] map_words_out,
   output var  logic                      grp_done_out,
   output var  logic [17:0]               grp_pgn_out,
   output var  logic [10:0]               grp_size_out,
   output var  logic                      grp_discard_out,
   output var  logic                      rx_busy_out,
   output var  logic [55:0]               rd_row_out,
   output var  logic                      dtc_valid_out,
   output var  logic [7:0]                dtc_lamps_out,
   output var  logic [8:0]                dtc_count_out
);
   initial begin
      if (BUF_BYTES < TP_MIN_BYTES || BUF_BYTES > TP_MAX_BYTES) $error("BUF_BYTES out of range");
      if (MAP_N < 1 || MAP_N * MAP_WORDS > 256) $error("MAP_N out of range");
   end

   // ------------------------------------------------------------
   // Frame decode
   // ------------------------------------------------------------
   typedef enum {ST_IDLE, ST_COLLECT} rx_state_t;

   logic [17:0] f_pgn;
   logic [7:0]  f_src;
   logic        addr_ok;
   logic        is_cm;
   logic        is_dt;
   cm_kind_t    cm_kind;
   bam_info_t   cand;
   logic        interested;
   logic        size_ok;

   always_comb begin
      f_pgn      = pgn_of(frame_in.id);
      f_src      = frame_in.id[7:0];
      addr_ok    = frame_in.id[15:8] == own_addr_in || frame_in.id[15:8] == ADDR_GLOBAL; // [RULE_04]
      is_cm      = frame_valid_in && f_pgn == PGN_TP_CM && addr_ok && frame_in.dlc == DLC_FULL;
      is_dt      = frame_valid_in && f_pgn == PGN_TP_DT && addr_ok && frame_in.dlc == DLC_FULL;
      cm_kind    = cm_decode(byte_of(frame_in.data, 1)); // [RULE_02]
      // Byte three low bits and byte eight low bits taken straight from the data
      cand.size  = {frame_in.data[42:40], byte_of(frame_in.data, 2)};
      cand.packets = byte_of(frame_in.data, 4);
      cand.pgn   = {frame_in.data[1:0], byte_of(frame_in.data, 7),
                    byte_of(frame_in.data, 6)};
      cand.src   = f_src;
      interested = cand.pgn == watch_pgn_in || cand.pgn == PGN_DM1; // [RULE_05] [RULE_11]
      // Packet count must match the size, else placement would overrun a row
      size_ok    = 32'(cand.size) >= TP_MIN_BYTES && 32'(cand.size) <= BUF_BYTES // [RULE_08]
                   && 32'(cand.packets) == (32'(cand.size) + DT_PAYLOAD - 1) / DT_PAYLOAD; // [RULE_01]
   end

   // ------------------------------------------------------------
   // Announce and reassembly
   // ------------------------------------------------------------
   rx_state_t       state_r, state_nxt;
   bam_info_t       info_r, info_nxt;
   logic [7:0]      rcvd_r, rcvd_nxt;
   logic [ROWS-1:0] seen_r, seen_nxt;
   logic [7:0]      lamp_r, lamp_nxt;
   logic            done_r, done_nxt;
   logic            discard_r, discard_nxt;
   logic            dtc_v_r, dtc_v_nxt;
   logic [7:0]      lamps_r, lamps_nxt;
   logic [8:0]      dtc_cnt_r, dtc_cnt_nxt;
   logic [17:0]     gpgn_r, gpgn_nxt;
   logic [10:0]     gsize_r, gsize_nxt;
   logic            busy_r, busy_nxt;
   logic            wr_en;
   logic [RW-1:0]   wr_row;
   logic [7:0]      seq;

   always_comb begin
      state_nxt   = state_r;
      info_nxt    = info_r;
      rcvd_nxt    = rcvd_r;
      seen_nxt    = seen_r;
      lamp_nxt    = lamp_r;
      done_nxt    = 1'b0;
      discard_nxt = 1'b0;
      dtc_v_nxt   = dtc_v_r;
      lamps_nxt   = lamps_r;
      dtc_cnt_nxt = dtc_cnt_r;
      gpgn_nxt    = gpgn_r;
      gsize_nxt   = gsize_r;
      wr_en       = 1'b0;
      seq         = byte_of(frame_in.data, 1);
      wr_row      = RW'(seq - 8'h01);
      if (is_cm) begin
         case (cm_kind)
            CM_BAM: begin
               if (interested && size_ok) begin
                  // A fresh announce restarts collection; nothing is answered
                  state_nxt = ST_COLLECT; // [RULE_05] [RULE_16]
                  info_nxt  = cand;
                  rcvd_nxt  = 8'h00;
                  seen_nxt  = '0;
               end else begin
                  discard_nxt = interested; // [RULE_16]
                  if (state_r == ST_COLLECT && info_r.src == f_src) begin
                     state_nxt = ST_IDLE;
                  end
               end
            end
            CM_ABORT: begin
               if (state_r == ST_COLLECT && info_r.src == f_src) begin
                  state_nxt = ST_IDLE;
               end
            end
            // Connection handshakes are not served: no reply, no state
            default: begin
               state_nxt = state_r; // [RULE_06]
            end
         endcase
      end else if (is_dt && state_r == ST_COLLECT && info_r.src == f_src
                   && seq != 8'h00 && seq <= info_r.packets) begin
         wr_en = 1'b1; // [RULE_03] [RULE_16]
         if (seq == 8'h01) begin
            lamp_nxt = byte_of(frame_in.data, 2);
         end
         if (!seen_r[wr_row]) begin
            seen_nxt[wr_row] = 1'b1;
            rcvd_nxt = rcvd_r + 8'h01;
            if (rcvd_nxt == info_r.packets) begin
               state_nxt = ST_IDLE;
               done_nxt  = 1'b1;
               gpgn_nxt  = info_r.pgn;
               gsize_nxt = info_r.size;
               if (info_r.pgn == PGN_DM1) begin
                  dtc_v_nxt   = 1'b1; // [RULE_12]
                  lamps_nxt   = (seq == 8'h01) ? byte_of(frame_in.data, 2) : lamp_r;
                  dtc_cnt_nxt = 9'((info_r.size - 11'h001) / DTC_BYTES);
               end
            end
         end
      end
      busy_nxt = state_nxt == ST_COLLECT;
   end

   // No timer anywhere: a stalled announce waits for the next one
   always_ff @(posedge clock_in or negedge rst_n_in) begin // [RULE_07]
      if (!rst_n_in) begin
         state_r   <= ST_IDLE;
         info_r    <= '0;
         rcvd_r    <= 8'h00;
         seen_r    <= '0;
         lamp_r    <= LAMPS_RST;
         done_r    <= 1'b0;
         discard_r <= 1'b0;
         dtc_v_r   <= 1'b0;
         lamps_r   <= LAMPS_RST;
         dtc_cnt_r <= 9'h000;
         gpgn_r    <= 18'h00000;
         gsize_r   <= 11'h000;
         busy_r    <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         info_r    <= info_nxt;
         rcvd_r    <= rcvd_nxt;
         seen_r    <= seen_nxt;
         lamp_r    <= lamp_nxt;
         done_r    <= done_nxt;
         discard_r <= discard_nxt;
         dtc_v_r   <= dtc_v_nxt;
         lamps_r   <= lamps_nxt;
         dtc_cnt_r <= dtc_cnt_nxt;
         gpgn_r    <= gpgn_nxt;
         gsize_r   <= gsize_nxt;
         busy_r    <= busy_nxt;
      end
   end

   reasm_buf #(
      .ROWS      (ROWS),
      .WIDTH     (8 * DT_PAYLOAD)
   ) u_buf (
      .clock_in  (clock_in),
      .rst_n_in  (rst_n_in),
      .we_in     (wr_en),
      .waddr_in  (wr_row),
      .wdata_in  (frame_in.data[55:0]),
      .raddr_in  (rd_row_in),
      .rdata_out (rd_row_out)
   );

   // ------------------------------------------------------------
   // Single-frame word mapping
   // ------------------------------------------------------------
   logic                         map_we_r, map_we_nxt;
   logic [7:0]                   map_base_r, map_base_nxt;
   logic [MAP_WORDS-1:0][15:0]   map_words_r, map_words_nxt;

   always_comb begin
      map_we_nxt    = 1'b0;
      map_base_nxt  = map_base_r;
      map_words_nxt = map_words_r;
      if (frame_valid_in && frame_in.dlc == DLC_FULL) begin // [RULE_01]
         for (int i = 0; i < MAP_N; i++) begin
            if (f_pgn == map_pgn_in[i] && !map_we_nxt) begin
               map_we_nxt   = 1'b1;
               map_base_nxt = 8'(i * MAP_WORDS); // [RULE_13]
            end
         end
         if (map_we_nxt) begin
            // Raw bytes only; scaling is left to the consumer
            for (int w = 0; w < MAP_WORDS; w++) begin
               map_words_nxt[w] = {byte_of(frame_in.data, 2 * w + 1),
                                   byte_of(frame_in.data, 2 * w + 2)}; // [RULE_15] [RULE_14]
            end
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         map_we_r    <= 1'b0;
         map_base_r  <= 8'h00;
         map_words_r <= '0;
      end else begin
         map_we_r    <= map_we_nxt;
         map_base_r  <= map_base_nxt;
         map_words_r <= map_words_nxt;
      end
   end

   always_comb begin
      map_we_out      = map_we_r;
      map_base_out    = map_base_r;
      map_words_out   = map_words_r;
      grp_done_out    = done_r;
      grp_pgn_out     = gpgn_r;
      grp_size_out    = gsize_r;
      grp_discard_out = discard_r;
      rx_busy_out     = busy_r;
      dtc_valid_out   = dtc_v_r;
      dtc_lamps_out   = lamps_r;
      dtc_count_out   = dtc_cnt_r;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_map_full_frame;
      @(posedge clock_in) disable iff (!rst_n_in)
      map_we_r |-> $past(frame_valid_in) && $past(frame_in.dlc) == DLC_FULL;
   endproperty
   a_map_full_frame: assert property (p_map_full_frame) else $error("map from short frame"); // [RULE_01]

   property p_handshake_ignored;
      @(posedge clock_in) disable iff (!rst_n_in)
      (is_cm && cm_kind inside {CM_RTS, CM_CTS, CM_ACK}) |=> state_r == $past(state_r);
   endproperty
   a_handshake_ignored: assert property (p_handshake_ignored) else $error("handshake moved state"); // [RULE_06]

   property p_seq_range;
      @(posedge clock_in) disable iff (!rst_n_in)
      wr_en |-> seq >= 8'h01 && seq <= info_r.packets && state_r == ST_COLLECT;
   endproperty
   a_seq_range: assert property (p_seq_range) else $error("bad sequence written"); // [RULE_03]

   property p_addr_start;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_r == ST_IDLE ##1 state_r == ST_COLLECT) |-> $past(addr_ok);
   endproperty
   a_addr_start: assert property (p_addr_start) else $error("foreign address started"); // [RULE_04]

   property p_size_limit;
      @(posedge clock_in) disable iff (!rst_n_in)
      state_r == ST_COLLECT |-> 32'(info_r.size) <= BUF_BYTES;
   endproperty
   a_size_limit: assert property (p_size_limit) else $error("group over buffer"); // [RULE_08]

   property p_oversize_drop;
      @(posedge clock_in) disable iff (!rst_n_in)
      (is_cm && cm_kind == CM_BAM && interested && 32'(cand.size) > BUF_BYTES)
         |=> grp_discard_out && !($past(state_r) == ST_IDLE && state_r == ST_COLLECT);
   endproperty
   a_oversize_drop: assert property (p_oversize_drop) else $error("oversize not dropped"); // [RULE_16]

   property p_word_order;
      @(posedge clock_in) disable iff (!rst_n_in)
      map_we_r |-> map_words_r[0] == $past(frame_in.data[63:48])
                   && map_words_r[MAP_WORDS-1] == $past(frame_in.data[15:0]);
   endproperty
   a_word_order: assert property (p_word_order) else $error("word byte order wrong"); // [RULE_15]

   property p_word_base;
      @(posedge clock_in) disable iff (!rst_n_in)
      map_we_r |-> map_base_r[1:0] == 2'b00 && map_pgn_in[map_base_r / MAP_WORDS] == $past(f_pgn);
   endproperty
   a_word_base: assert property (p_word_base) else $error("mapped words misplaced"); // [RULE_13]

   property p_no_timeout;
      @(posedge clock_in) disable iff (!rst_n_in)
      (state_r == ST_COLLECT && !frame_valid_in) |=> state_r == ST_COLLECT;
   endproperty
   a_no_timeout: assert property (p_no_timeout) else $error("collection timed out"); // [RULE_07]

   property p_done_only_interest;
      @(posedge clock_in) disable iff (!rst_n_in)
      grp_done_out |-> $past(rcvd_r) + 8'h01 == $past(info_r.packets)
                       && (grp_pgn_out == PGN_DM1 || grp_pgn_out == $past(watch_pgn_in, 2)
                           || $past(state_r, 2) == ST_COLLECT);
   endproperty
   a_done_only_interest: assert property (p_done_only_interest) else $error("done early"); // [RULE_05]

   property p_dtc_group;
      @(posedge clock_in) disable iff (!rst_n_in)
      (grp_done_out && grp_pgn_out == PGN_DM1)
         |-> dtc_valid_out && 32'(dtc_count_out) == (32'(grp_size_out) - 1) / DTC_BYTES;
   endproperty
   a_dtc_group: assert property (p_dtc_group) else $error("diagnostic summary wrong"); // [RULE_12] [RULE_11]

endmodule : j1939_bam_multipacket_receiver
`default_nettype wire

// ===== design/j1939_rx_pkg.sv
package j1939_rx_pkg;

   // ------------------------------------------------------------
   // Group numbers, control codes, addresses
   // ------------------------------------------------------------
   localparam logic [17:0] PGN_TP_CM   = 18'h0EC00;
   localparam logic [17:0] PGN_TP_DT   = 18'h0EB00;
   localparam logic [17:0] PGN_DM1     = 18'h0FECA;
   localparam logic [7:0]  CTL_RTS     = 8'h10;
   localparam logic [7:0]  CTL_CTS     = 8'h11;
   localparam logic [7:0]  CTL_ACK     = 8'h13;
   localparam logic [7:0]  CTL_BAM     = 8'h20;
   localparam logic [7:0]  CTL_ABORT   = 8'hFF;
   localparam logic [7:0]  ADDR_GLOBAL = 8'hFF;
   localparam logic [7:0]  PDU2_MIN_PF = 8'hF0;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int          SF_MAX_BYTES = 8;
   localparam int          TP_MIN_BYTES = 9;
   localparam int          TP_MAX_BYTES = 1785;
   localparam int          BUF_LIMIT    = 500;
   localparam int          DT_PAYLOAD   = 7;
   localparam int          MAP_WORDS    = 4;
   localparam int          DTC_BYTES    = 4;
   localparam logic [3:0]  DLC_FULL     = 4'h8;
   localparam logic [7:0]  LAMPS_RST    = 8'h00;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [28:0] id;
      logic [3:0]  dlc;
      logic [63:0] data;
   } can_frame_t;

   typedef struct packed {
      logic [17:0] pgn;
      logic [10:0] size;
      logic [7:0]  packets;
      logic [7:0]  src;
   } bam_info_t;

   typedef enum logic [2:0] {CM_BAM, CM_RTS, CM_CTS, CM_ACK, CM_ABORT, CM_OTHER} cm_kind_t;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Destination-specific formats carry the address in PS, not in the group number
   function automatic logic [17:0] pgn_of(input logic [28:0] id);
      pgn_of = (id[23:16] < PDU2_MIN_PF) ? {id[25:16], 8'h00} : id[25:8];
   endfunction : pgn_of

   function automatic logic [7:0] byte_of(input logic [63:0] d, input int n);
      byte_of = d[71 - 8 * n -: 8];
   endfunction : byte_of

   function automatic cm_kind_t cm_decode(input logic [7:0] c);
      case (c)
         CTL_BAM:   cm_decode = CM_BAM;
         CTL_RTS:   cm_decode = CM_RTS;
         CTL_CTS:   cm_decode = CM_CTS;
         CTL_ACK:   cm_decode = CM_ACK;
         CTL_ABORT: cm_decode = CM_ABORT;
         default:   cm_decode = CM_OTHER;
      endcase
   endfunction : cm_decode

endpackage : j1939_rx_pkg

// ===== design/reasm_buf.sv
`timescale 1ns/100ps
`default_nettype none
module reasm_buf #(
   parameter int ROWS  = 72,
   parameter int WIDTH = 56
) (
   input  wire logic                    clock_in,
   input  wire logic                    rst_n_in,
   input  wire logic                    we_in,
   input  wire logic [$clog2(ROWS)-1:0] waddr_in,
   input  wire logic [WIDTH-1:0]        wdata_in,
   input  wire logic [$clog2(ROWS)-1:0] raddr_in,
   output var  logic [WIDTH-1:0]        rdata_out
);
   logic [WIDTH-1:0] mem [ROWS];
   logic [WIDTH-1:0] rdata_nxt;

   initial begin
      if (ROWS < 2) $error("reasm_buf needs at least two rows");
   end

   always_comb begin
      rdata_nxt = mem[raddr_in];
   end

   always_ff @(posedge clock_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= rdata_nxt;
      end
   end
endmodule : reasm_buf
`default_nettype wire

// ===== bench/can_node_model.sv
`timescale 1ns/100ps
`default_nettype none
module can_node_model
   import j1939_rx_pkg::*;
(
   input  wire logic       clock_in,
   output var  logic       valid_out,
   output var  can_frame_t frame_out
);
   initial begin
      valid_out = 1'b0;
      frame_out = '0;
   end

   // ------------------------------------------------------------
   // Frame builders
   // ------------------------------------------------------------
   function automatic logic [28:0] mk_id(input logic [17:0] pgn, input logic [7:0] dst,
                                         input logic [7:0] src);
      if (pgn[15:8] < PDU2_MIN_PF) mk_id = {3'h6, pgn[17:8], dst, src};
      else mk_id = {3'h6, pgn, src};
   endfunction : mk_id

   // Caller stands at a rising edge; returns at the edge that takes the frame
   task automatic send(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
      valid_out <= 1'b1;
      frame_out <= '{id: id, dlc: dlc, data: d};
      @(posedge clock_in);
      // Idle bus shows the inverse, so a stale frame never looks valid
      valid_out <= 1'b0;
      frame_out <= '{id: ~id, dlc: ~dlc, data: ~d};
   endtask : send

   // Only ever the sender, but of any control code given: clear, acknowledge and abort included
   task automatic cm(input logic [7:0] ctl, input logic [10:0] size, input logic [7:0] pk,
                     input logic [17:0] pgn, input logic [7:0] dst, input logic [7:0] src);
      send(mk_id(PGN_TP_CM, dst, src), DLC_FULL, {ctl, size[7:0], 5'h00, size[10:8], pk,
           8'hFF, pgn[7:0], pgn[15:8], 6'h00, pgn[17:16]});
   endtask : cm

   task automatic dt(input logic [7:0] seq, input logic [55:0] pl, input logic [7:0] dst,
                     input logic [7:0] src);
      send(mk_id(PGN_TP_DT, dst, src), DLC_FULL, {seq, pl});
   endtask : dt
endmodule : can_node_model
`default_nettype wire

// ===== bench/j1939_bam_multipacket_receiver_tb.sv
`timescale 1ns/100ps
`default_nettype none
module j1939_bam_multipacket_receiver_tb
   import j1939_rx_pkg::*;
;
   logic                   clock_in, rst_n_in, frame_valid, map_we, grp_done, grp_discard;
   logic                   rx_busy, dtc_valid;
   can_frame_t             frame;
   logic [7:0]             own_addr, map_base, dtc_lamps;
   logic [17:0]            watch_pgn, grp_pgn;
   logic [1:0][17:0]       map_pgn;
   logic [6:0]             rd_row;
   logic [3:0][15:0]       map_words;
   logic [10:0]            grp_size;
   logic [55:0]            row_q;
   logic [8:0]             dtc_count;
   logic [31:0]            seed;
   logic [7:0]             gb[$];
   int                     n_fail, samples_checked;

   can_node_model u_node (.clock_in(clock_in), .valid_out(frame_valid), .frame_out(frame));

   j1939_bam_multipacket_receiver #(.BUF_BYTES(500), .MAP_N(2)) u_dut (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .frame_valid_in(frame_valid),
      .frame_in(frame), .own_addr_in(own_addr), .watch_pgn_in(watch_pgn),
      .map_pgn_in(map_pgn), .rd_row_in(rd_row), .map_we_out(map_we),
      .map_base_out(map_base), .map_words_out(map_words), .grp_done_out(grp_done),
      .grp_pgn_out(grp_pgn), .grp_size_out(grp_size), .grp_discard_out(grp_discard),
      .rx_busy_out(rx_busy), .rd_row_out(row_q), .dtc_valid_out(dtc_valid),
      .dtc_lamps_out(dtc_lamps), .dtc_count_out(dtc_count));

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed[7:0];
   endfunction : rnd

   task automatic chk_val(input string what, input logic [63:0] exp, input logic [63:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk_val

   // Pulses stand just after the taking edge, for one cycle
   task automatic post(input logic we, input logic done, input logic disc);
      #1;
      chk_val("map_we", {63'h0, we}, {63'h0, map_we});
      chk_val("grp_done", {63'h0, done}, {63'h0, grp_done});
      chk_val("grp_discard", {63'h0, disc}, {63'h0, grp_discard});
      @(posedge clock_in);
   endtask : post

   task automatic chk_row(input int r);
      logic [55:0] e;
      for (int k = 0; k < 7; k++) e[55-8*k -: 8] = gb[7*r+k];
      rd_row <= 7'(r);
      @(posedge clock_in);
      #1;
      chk_val("row", {8'h00, e}, {8'h00, row_q});
      @(posedge clock_in);
   endtask : chk_row

   task automatic xfer(input logic [17:0] pgn, input int size, input logic [7:0] dst,
                       input bit rev, input bit stray);
      int pk, s;
      logic [55:0] pl;
      pk = (size + 6) / 7;
      gb.delete();
      for (int i = 0; i < pk * 7; i++) gb.push_back(rnd());
      u_node.cm(CTL_BAM, 11'(size), 8'(pk), pgn, dst, 8'h31);
      post(0, 0, 0);
      chk_val("rx_busy", 64'h1, {63'h0, rx_busy});
      repeat (300) @(posedge clock_in);
      if (stray) begin
         u_node.dt(8'(rev ? 1 : pk), {7{8'hA5}}, own_addr + 8'h01, 8'h31);
         post(0, 0, 0);
      end
      for (int i = 0; i < pk; i++) begin
         s = rev ? pk - i : i + 1;
         for (int k = 0; k < 7; k++) pl[55-8*k -: 8] = gb[7*(s-1)+k];
         u_node.dt(8'(s), pl, dst, 8'h31);
         post(0, i == pk - 1, 0);
      end
      chk_val("grp_pgn", {46'h0, pgn}, {46'h0, grp_pgn});
      chk_val("grp_size", 64'(size), {53'h0, grp_size});
      chk_row(0);
      chk_row(pk - 1);
   endtask : xfer

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      logic [63:0] d;
      logic [7:0]  ctls[3];
      seed = 32'hC18E;
      n_fail = 0;
      samples_checked = 0;
      rst_n_in = 1'b0;
      rd_row = 7'h00;
      own_addr = 8'h2A;
      watch_pgn = 18'h0FEE3;
      map_pgn = {18'h0FEEE, 18'h0F004};
      ctls = '{CTL_RTS, CTL_CTS, CTL_ACK};
      repeat (2) @(posedge clock_in);
      rst_n_in <= 1'b1;
      @(posedge clock_in);
      #1;
      chk_val("rx_busy", 64'h0, {63'h0, rx_busy});
      chk_val("dtc_valid", 64'h0, {63'h0, dtc_valid});
      @(posedge clock_in);
      for (int i = 0; i < 2; i++) begin
         d = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
         u_node.send(u_node.mk_id(map_pgn[i], 8'h00, rnd()), DLC_FULL, d);
         post(1, 0, 0);
         chk_val("map_base", 64'(4 * i), {56'h0, map_base});
         chk_val("map_words", {d[15:0], d[31:16], d[47:32], d[63:48]}, map_words);
      end
      u_node.send(u_node.mk_id(map_pgn[0], 8'h00, 8'h10), 4'h7, d);
      post(0, 0, 0);
      $display("test map done");
      foreach (ctls[i]) begin
         u_node.cm(ctls[i], 11'd20, 8'd3, watch_pgn, own_addr, 8'h44);
         post(0, 0, 0);
         chk_val("rx_busy", 64'h0, {63'h0, rx_busy});
      end
      u_node.cm(CTL_BAM, 11'd20, 8'd3, 18'h0F004, ADDR_GLOBAL, 8'h44);
      post(0, 0, 0);
      chk_val("rx_busy", 64'h0, {63'h0, rx_busy});
      $display("test control codes done");
      xfer(watch_pgn, 500, ADDR_GLOBAL, 1, 1);
      xfer(watch_pgn, 9, own_addr, 0, 1);
      $display("test transfers done");
      u_node.cm(CTL_BAM, 11'd501, 8'd72, watch_pgn, ADDR_GLOBAL, 8'h31);
      post(0, 0, 1);
      u_node.cm(CTL_BAM, 11'd20, 8'd4, watch_pgn, ADDR_GLOBAL, 8'h31);
      post(0, 0, 1);
      chk_val("rx_busy", 64'h0, {63'h0, rx_busy});
      $display("test discard done");
      xfer(PGN_DM1, 13, ADDR_GLOBAL, 0, 0);
      chk_val("dtc_valid", 64'h1, {63'h0, dtc_valid});
      chk_val("dtc_lamps", {56'h0, gb[0]}, {56'h0, dtc_lamps});
      chk_val("dtc_count", 64'd3, {55'h0, dtc_count});
      $display("test diagnostic done");
      u_node.cm(CTL_BAM, 11'd14, 8'd2, watch_pgn, ADDR_GLOBAL, 8'h31);
      post(0, 0, 0);
      u_node.cm(CTL_ABORT, 11'd14, 8'd2, watch_pgn, ADDR_GLOBAL, 8'h31);
      post(0, 0, 0);
      chk_val("rx_busy", 64'h0, {63'h0, rx_busy});
      for (int s = 1; s < 3; s++) begin
         u_node.dt(8'(s), {7{rnd()}}, ADDR_GLOBAL, 8'h31);
         post(0, 0, 0);
      end
      $display("test abort done");
      wrap_up();
   end

   // Far above the roughly 1100 cycles the tests need
   initial begin
      #400000;
      n_fail++;
      wrap_up();
   end
endmodule : j1939_bam_multipacket_receiver_tb
`default_nettype wire
